// [design/lndf_params.svh]
// Purpose: Constants for the line diagnostic filter block
// Assumes: 25 MHz clock, byte addresses on AXI4-Lite
// Notes:   Operation
// Operation
// (R1) Monitor samples arrive at 800 Hz, giving dc to 400 Hz bandwidth.
// (R2) Metallic and longitudinal values are computed from tip and ring, readable.
// (R3) Converter has high and low ranges with different step sizes.
// (R4) Filter enable starts per-channel monitor filters, channels independent.
// (R5) Monitor filters run only while voice band processing is idle.
// (R6) Off-hook or ring trip while enabled clears the enable.
// (R7) Input select 0..7 picks one of eight line quantities.
// (R8) Peak reports unsigned magnitude of largest value since last clear.
// (R9) Dc path is one-pole low-pass with writable coefficient, readable result.
// (R10) Ac path rectifies then one-pole low-pass with writable coefficient.
// (R11) Enable rise or select change clears peak and flushes filters.
// (R12) Host writing 0 to peak restarts peak capture from that write.
// (R13) Transmit filter is three cascaded biquads at 8 kHz.
// (R14) Each biquad has five 25-bit coefficients a1 a2 b0 b1 b2.
// (R15) Unity coefficients make a section pass its input unchanged.
// (R16) Transmit peak uses host window length, updated each window end.
// (R17) Transmit power is one-pole average of filter output, readable.
// (R18) Unbalanced-ringing select bit steers the low-level test ringing.
// (R19) Monitor filters advance once per sample while enabled, else hold.
`ifndef LNDF_PARAMS_SVH
`define LNDF_PARAMS_SVH
`define LNDF_CLK_HZ      25000000
`define LNDF_MON_HZ      800
`define LNDF_MON_DIV     (`LNDF_CLK_HZ / `LNDF_MON_HZ)
`define LNDF_TX_HZ       8000
`define LNDF_TX_DIV      (`LNDF_CLK_HZ / `LNDF_TX_HZ)
`define LNDF_IX_CTRL     3'h0
`define LNDF_IX_DCCO     3'h1
`define LNDF_IX_ACCO     3'h2
`define LNDF_IX_PEAK     3'h3
`define LNDF_IX_DCRES    3'h4
`define LNDF_IX_ACRES    3'h5
`define LNDF_IX_METAL    3'h6
`define LNDF_IX_LONG     3'h7
`define LNDF_ADR_CHEND   8'h40
`define LNDF_ADR_RING    8'h40
`define LNDF_ADR_WLN     8'h44
`define LNDF_ADR_TXPK    8'h48
`define LNDF_ADR_PWK     8'h4c
`define LNDF_ADR_PWR     8'h50
`define LNDF_ADR_BQ      8'h80
`define LNDF_ADR_BQEND   8'hbc
`define LNDF_CTRL_EN     0
`define LNDF_RST_DCCO    16'h0200
`define LNDF_RST_ACCO    16'h0200
`define LNDF_RST_WLN     16'h0320
`define LNDF_RST_PWK     16'h0100
`define LNDF_COEF_ONE    25'h0400000
`define LNDF_COEF_FB     22
`define LNDF_RESP_OK     2'h0
`define LNDF_RESP_DEC    2'h3
`endif

// [design/lndf_pkg.sv]
// Purpose: Types and shared arithmetic for the line diagnostic filters
// Assumes: Signed two's complement samples
// Notes:   Low-pass shared by monitor and power paths
`default_nettype none
package lndf_pkg;
  typedef enum logic [2:0] {
    LNDF_TIP_V = 3'h0, LNDF_RING_V = 3'h1, LNDF_LOOP_V = 3'h2, LNDF_LONG_V = 3'h3,
    LNDF_LOOP_I = 3'h4, LNDF_LONG_I = 3'h5, LNDF_EXT_V = 3'h6, LNDF_EXT_I = 3'h7
  } lndf_sel_t;
  typedef logic signed [16:0] lndf_acc_t;
  // One-pole low-pass: y += (x - y) * k / 65536
  function automatic lndf_acc_t lndf_lp(input lndf_acc_t y, input lndf_acc_t x,
                                        input logic [15:0] k);
    logic signed [17:0] d;
    logic signed [34:0] p;
    d = 18'(x) - 18'(y);
    p = d * $signed({1'b0, k});
    return 17'(y + 17'(p >>> 16));
  endfunction
endpackage
`default_nettype wire

// [design/lndf_top.sv]
// Purpose: Two-channel monitor filters and transmit diagnostic filter with AXI4-Lite
// Assumes: Inputs synchronous to I_CLOCK; monitor samples signed 8-bit per channel
// Notes:   Range choice of the converter only scales codes; filters see raw codes
`include "lndf_params.svh"
`default_nettype none
// ======================================================================
// Monitor channel: input select, peak, dc and ac paths
module lndf_mon_chan (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_tick,
  input  wire logic              i_run,
  input  wire logic              i_flush,
  input  wire logic              i_pk_clr,
  input  wire logic [2:0]        i_sel,
  input  wire logic signed [7:0] i_tip_v,
  input  wire logic signed [7:0] i_ring_v,
  input  wire logic signed [7:0] i_tip_i,
  input  wire logic signed [7:0] i_ring_i,
  input  wire logic signed [7:0] i_ext_v,
  input  wire logic signed [7:0] i_ext_i,
  input  wire logic [15:0]       i_dc_k,
  input  wire logic [15:0]       i_ac_k,
  output logic [8:0]             o_peak,
  output lndf_pkg::lndf_acc_t    o_dc,
  output lndf_pkg::lndf_acc_t    o_ac,
  output logic signed [8:0]      o_metal,
  output logic signed [7:0]      o_long
);
  wire logic signed [8:0] vloop = 9'(i_tip_v) - 9'(i_ring_v);
  wire logic signed [8:0] vsum  = 9'(i_tip_v) + 9'(i_ring_v);
  wire logic signed [8:0] iloop = 9'(i_tip_i) - 9'(i_ring_i);
  wire logic signed [8:0] isum  = 9'(i_tip_i) + 9'(i_ring_i);
  wire logic signed [8:0] src [8];
  // Either converter range delivers the same 8-bit code, so the paths ignore the range
  assign src[lndf_pkg::LNDF_TIP_V]  = 9'(i_tip_v); // [R7] [R3]
  assign src[lndf_pkg::LNDF_RING_V] = 9'(i_ring_v);
  assign src[lndf_pkg::LNDF_LOOP_V] = vloop;
  assign src[lndf_pkg::LNDF_LONG_V] = 9'(vsum >>> 1);
  assign src[lndf_pkg::LNDF_LOOP_I] = iloop;
  assign src[lndf_pkg::LNDF_LONG_I] = 9'(isum >>> 1);
  assign src[lndf_pkg::LNDF_EXT_V]  = 9'(i_ext_v);
  assign src[lndf_pkg::LNDF_EXT_I]  = 9'(i_ext_i);
  wire logic signed [8:0] x   = src[i_sel];
  wire logic [8:0]        mag = x[8] ? 9'(-x) : x; // [R8] [R10]
  wire logic              adv = i_tick && i_run; // [R19]
  wire logic [8:0] pk_base = i_pk_clr ? 9'h0 : o_peak; // [R12]
  wire logic [8:0] peak_next = i_flush ? 9'h0 :
                   (adv && mag > pk_base) ? mag : pk_base; // [R8] [R11]
  wire lndf_pkg::lndf_acc_t dc_next = i_flush ? 17'h0 :
       adv ? lndf_pkg::lndf_lp(o_dc, {x, 8'h0}, i_dc_k) : o_dc; // [R9] [R11]
  wire lndf_pkg::lndf_acc_t ac_next = i_flush ? 17'h0 :
       adv ? lndf_pkg::lndf_lp(o_ac, {mag, 8'h0}, i_ac_k) : o_ac; // [R10] [R11]
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_peak  <= 9'h0;
      o_dc    <= 17'h0;
      o_ac    <= 17'h0;
      o_metal <= 9'h0;
      o_long  <= 8'h0;
    end
    else
    begin
      o_peak <= peak_next;
      o_dc   <= dc_next;
      o_ac   <= ac_next;
      if (i_tick)
      begin
        o_metal <= vloop; // [R2]
        o_long  <= vsum[8:1];
      end
    end
  end
  chk_flush_clears: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
    i_flush |=> o_peak == 9'h0 && o_dc == 17'h0 && o_ac == 17'h0)
    else $error("flush left filter state");
  chk_idle_holds: assert property (@(posedge i_clk) disable iff (i_rst) // [R19]
    !adv && !i_flush && !i_pk_clr |=> $stable(o_peak) && $stable(o_dc) && $stable(o_ac))
    else $error("monitor filters moved without a sample");
  chk_peak_grows: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
    adv && !i_flush && !i_pk_clr |=> o_peak >= $past(o_peak) && o_peak >= $past(mag))
    else $error("peak below largest magnitude");
  chk_peak_restart: assert property (@(posedge i_clk) disable iff (i_rst) // [R12]
    i_pk_clr && !adv |=> o_peak == 9'h0)
    else $error("peak not restarted by host write");
  chk_metal_calc: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
    i_tick |=> o_metal == $past(vloop) && o_long == $past(vsum[8:1]))
    else $error("metallic or longitudinal value wrong");
endmodule
// ======================================================================
// Second-order section, direct form I, coefficients Q2.22
module lndf_biquad (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_tick,
  input  wire logic signed [15:0] i_x,
  input  wire logic signed [24:0] i_a1,
  input  wire logic signed [24:0] i_a2,
  input  wire logic signed [24:0] i_b0,
  input  wire logic signed [24:0] i_b1,
  input  wire logic signed [24:0] i_b2,
  output logic signed [15:0]      o_y
);
  logic signed [15:0] x1_reg;
  logic signed [15:0] x2_reg;
  logic signed [15:0] y2_reg;
  // Denominator is 1 - a1 z^-1 - a2 z^-2, so feedback terms add
  wire logic signed [43:0] acc = 44'(i_b0 * i_x) + 44'(i_b1 * x1_reg) + 44'(i_b2 * x2_reg)
                               + 44'(i_a1 * o_y) + 44'(i_a2 * y2_reg); // [R14]
  wire logic signed [43:0] sh = acc >>> `LNDF_COEF_FB;
  // Saturate so an unstable program clips instead of wrapping
  wire logic signed [15:0] y_next = (sh > 44'sd32767) ? 16'sh7fff :
                                    (sh < -44'sd32768) ? -16'sh8000 : sh[15:0];
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      x1_reg <= 16'h0;
      x2_reg <= 16'h0;
      y2_reg <= 16'h0;
      o_y    <= 16'h0;
    end
    else if (i_tick)
    begin
      x1_reg <= i_x;
      x2_reg <= x1_reg;
      y2_reg <= o_y;
      o_y    <= y_next;
    end
  end
  chk_unity_pass: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
    i_tick && i_a1 == 25'h0 && i_a2 == 25'h0 && i_b0 == `LNDF_COEF_ONE
    && i_b1 == 25'h0 && i_b2 == 25'h0 |=> o_y == $past(i_x))
    else $error("unity section changed its input");
endmodule
// ======================================================================
// Top: bus slave, dividers, two monitor channels, transmit diagnostics
module lndf_top #(
  parameter int MON_DIV = `LNDF_MON_DIV,
  parameter int TX_DIV  = `LNDF_TX_DIV
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  input  wire logic [15:0] I_TIP_V,
  input  wire logic [15:0] I_RING_V,
  input  wire logic [15:0] I_TIP_I,
  input  wire logic [15:0] I_RING_I,
  input  wire logic [15:0] I_EXT_V,
  input  wire logic [15:0] I_EXT_I,
  input  wire logic [1:0]  I_OFF_HOOK,
  input  wire logic [1:0]  I_RING_TRIP,
  input  wire logic [1:0]  I_VOICE_ACTIVE,
  input  wire logic [15:0] I_TX_SAMPLE,
  output logic             O_RING_UNBAL
);
  // ====================================================================
  // Rate dividers
  logic [15:0] mon_cnt_reg;
  logic [15:0] tx_cnt_reg;
  logic        mon_tick_reg;
  logic        tx_tick_reg;
  wire logic mon_wrap = mon_cnt_reg == 16'(MON_DIV - 1); // [R1]
  wire logic tx_wrap  = tx_cnt_reg == 16'(TX_DIV - 1); // [R13]
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      mon_cnt_reg  <= 16'h0;
      tx_cnt_reg   <= 16'h0;
      mon_tick_reg <= 1'b0;
      tx_tick_reg  <= 1'b0;
    end
    else
    begin
      mon_cnt_reg  <= mon_wrap ? 16'h0 : mon_cnt_reg + 16'h1;
      tx_cnt_reg   <= tx_wrap ? 16'h0 : tx_cnt_reg + 16'h1;
      mon_tick_reg <= mon_wrap;
      tx_tick_reg  <= tx_wrap;
    end
  end
  // ====================================================================
  // Registers
  logic [3:0]         ctrl_reg [2];
  logic [15:0]        dcco_reg [2];
  logic [15:0]        acco_reg [2];
  logic               ring_reg;
  logic [15:0]        wln_reg;
  logic [15:0]        pwk_reg;
  logic [24:0]        coef_reg [15];
  logic [15:0]        tx_pk_reg;
  lndf_pkg::lndf_acc_t pwr_reg;
  logic [8:0]         pk_w [2];
  lndf_pkg::lndf_acc_t dc_w [2];
  lndf_pkg::lndf_acc_t ac_w [2];
  logic signed [8:0]  ml_w [2];
  logic signed [7:0]  lg_w [2];
  // ====================================================================
  // AXI4-Lite slave
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  wire logic aw_hs  = I_AWVALID && O_AWREADY;
  wire logic w_hs   = I_WVALID && O_WREADY;
  wire logic wr_do  = !O_AWREADY && !O_WREADY && !O_BVALID;
  wire logic [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                             {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && (a <= `LNDF_ADR_PWR || (a >= `LNDF_ADR_BQ && a < `LNDF_ADR_BQEND));
  endfunction
  function automatic logic [31:0] rdmux(input logic [7:0] a);
    logic        c;
    logic [7:0]  bq;
    c  = a[5];
    bq = 8'(a - `LNDF_ADR_BQ) >> 2;
    if (!mapped(a))
      return 32'h0;
    if (a < `LNDF_ADR_CHEND)
      case (a[4:2])
        `LNDF_IX_CTRL:  return 32'(ctrl_reg[c]);
        `LNDF_IX_DCCO:  return 32'(dcco_reg[c]);
        `LNDF_IX_ACCO:  return 32'(acco_reg[c]);
        `LNDF_IX_PEAK:  return 32'(pk_w[c]);
        `LNDF_IX_DCRES: return 32'(dc_w[c]);
        `LNDF_IX_ACRES: return 32'(ac_w[c]);
        `LNDF_IX_METAL: return 32'(ml_w[c]);
        default:        return 32'(lg_w[c]);
      endcase
    case (a)
      `LNDF_ADR_RING: return 32'(ring_reg);
      `LNDF_ADR_WLN:  return 32'(wln_reg);
      `LNDF_ADR_TXPK: return 32'(tx_pk_reg);
      `LNDF_ADR_PWK:  return 32'(pwk_reg);
      `LNDF_ADR_PWR:  return 32'(pwr_reg);
      default:        return 32'(coef_reg[bq[3:0]]);
    endcase
  endfunction
  wire logic [31:0] wr_val = (rdmux(aw_addr_reg) & ~wmask) | (w_data_reg & wmask);
  wire logic        wr_ch  = wr_do && mapped(aw_addr_reg) && aw_addr_reg < `LNDF_ADR_CHEND;
  wire logic [7:0]  wr_bq  = 8'(aw_addr_reg - `LNDF_ADR_BQ) >> 2;
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_AWREADY   <= 1'b1;
      O_WREADY    <= 1'b1;
      O_BVALID    <= 1'b0;
      O_BRESP     <= `LNDF_RESP_OK;
      O_ARREADY   <= 1'b1;
      O_RVALID    <= 1'b0;
      O_RDATA     <= 32'h0;
      O_RRESP     <= `LNDF_RESP_OK;
      aw_addr_reg <= 8'h0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_addr_reg <= I_AWADDR;
        O_AWREADY   <= 1'b0;
      end
      if (w_hs)
      begin
        w_data_reg <= I_WDATA;
        w_strb_reg <= I_WSTRB;
        O_WREADY   <= 1'b0;
      end
      if (wr_do)
      begin
        O_BVALID <= 1'b1;
        O_BRESP  <= mapped(aw_addr_reg) ? `LNDF_RESP_OK : `LNDF_RESP_DEC;
      end
      if (O_BVALID && I_BREADY)
      begin
        O_BVALID  <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY  <= 1'b1;
      end
      if (I_ARVALID && O_ARREADY)
      begin
        O_ARREADY <= 1'b0;
        O_RVALID  <= 1'b1;
        O_RDATA   <= rdmux(I_ARADDR);
        O_RRESP   <= mapped(I_ARADDR) ? `LNDF_RESP_OK : `LNDF_RESP_DEC;
      end
      if (O_RVALID && I_RREADY)
      begin
        O_RVALID  <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end
  // ====================================================================
  // Shared registers
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      ring_reg     <= 1'b0;
      O_RING_UNBAL <= 1'b0;
      wln_reg      <= `LNDF_RST_WLN;
      pwk_reg      <= `LNDF_RST_PWK;
      for (int i = 0; i < 15; i++)
        coef_reg[i] <= (i % 5 == 2) ? `LNDF_COEF_ONE : 25'h0; // [R15]
    end
    else
    begin
      O_RING_UNBAL <= ring_reg; // [R18]
      if (wr_do && aw_addr_reg == `LNDF_ADR_RING)
        ring_reg <= wr_val[0];
      if (wr_do && aw_addr_reg == `LNDF_ADR_WLN)
        wln_reg <= wr_val[15:0]; // [R16]
      if (wr_do && aw_addr_reg == `LNDF_ADR_PWK)
        pwk_reg <= wr_val[15:0]; // [R17]
      if (wr_do && aw_addr_reg >= `LNDF_ADR_BQ && mapped(aw_addr_reg))
        coef_reg[wr_bq[3:0]] <= wr_val[24:0]; // [R14]
    end
  end
  // ====================================================================
  // Monitor channels, each with its own control and filters
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    wire logic       wr_here = wr_ch && aw_addr_reg[5] == 1'(c);
    wire logic       wr_ctrl = wr_here && aw_addr_reg[4:2] == `LNDF_IX_CTRL;
    wire logic       en      = ctrl_reg[c][`LNDF_CTRL_EN];
    wire logic       trip    = I_OFF_HOOK[c] || I_RING_TRIP[c];
    wire logic       flush   = wr_ctrl && ((wr_val[0] && !en)
                               || wr_val[3:1] != ctrl_reg[c][3:1]); // [R11]
    wire logic       pk_clr  = wr_here && aw_addr_reg[4:2] == `LNDF_IX_PEAK
                               && wr_val == 32'h0; // [R12]
    wire logic       run     = en && !I_VOICE_ACTIVE[c]; // [R4] [R5]
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
      if (I_RST)
      begin
        ctrl_reg[c] <= 4'h0;
        dcco_reg[c] <= `LNDF_RST_DCCO;
        acco_reg[c] <= `LNDF_RST_ACCO;
      end
      else
      begin
        if (wr_ctrl)
          ctrl_reg[c] <= wr_val[3:0];
        // Line state overrides a simultaneous software enable
        if (trip && (en || wr_ctrl))
          ctrl_reg[c][`LNDF_CTRL_EN] <= 1'b0; // [R6]
        if (wr_here && aw_addr_reg[4:2] == `LNDF_IX_DCCO)
          dcco_reg[c] <= wr_val[15:0]; // [R9]
        if (wr_here && aw_addr_reg[4:2] == `LNDF_IX_ACCO)
          acco_reg[c] <= wr_val[15:0]; // [R10]
      end
    end
    lndf_mon_chan u_chan (
      .i_clk    (I_CLOCK),
      .i_rst    (I_RST),
      .i_tick   (mon_tick_reg),
      .i_run    (run),
      .i_flush  (flush),
      .i_pk_clr (pk_clr),
      .i_sel    (ctrl_reg[c][3:1]),
      .i_tip_v  (I_TIP_V[8*c +: 8]),
      .i_ring_v (I_RING_V[8*c +: 8]),
      .i_tip_i  (I_TIP_I[8*c +: 8]),
      .i_ring_i (I_RING_I[8*c +: 8]),
      .i_ext_v  (I_EXT_V[8*c +: 8]),
      .i_ext_i  (I_EXT_I[8*c +: 8]),
      .i_dc_k   (dcco_reg[c]),
      .i_ac_k   (acco_reg[c]),
      .o_peak   (pk_w[c]),
      .o_dc     (dc_w[c]),
      .o_ac     (ac_w[c]),
      .o_metal  (ml_w[c]),
      .o_long   (lg_w[c])
    );
    chk_trip_clears: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R6]
      trip |=> !ctrl_reg[c][`LNDF_CTRL_EN])
      else $error("enable survived off-hook or ring trip");
    chk_voice_holds: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R5]
      I_VOICE_ACTIVE[c] && !flush && !pk_clr |=> $stable(dc_w[c]) && $stable(pk_w[c]))
      else $error("monitor filter ran during voice processing");
  end
  // ====================================================================
  // Transmit diagnostics: three sections, windowed peak, power average
  logic signed [15:0] stg_y [4];
  assign stg_y[0] = I_TX_SAMPLE;
  for (genvar s = 0; s < 3; s++)
  begin : g_bq
    lndf_biquad u_bq (
      .i_clk  (I_CLOCK),
      .i_rst  (I_RST),
      .i_tick (tx_tick_reg),
      .i_x    (stg_y[s]),
      .i_a1   (coef_reg[5*s]),
      .i_a2   (coef_reg[5*s+1]),
      .i_b0   (coef_reg[5*s+2]),
      .i_b1   (coef_reg[5*s+3]),
      .i_b2   (coef_reg[5*s+4]),
      .o_y    (stg_y[s+1])
    ); // [R13]
  end
  logic [15:0] win_cnt_reg;
  logic [15:0] run_max_reg;
  wire logic signed [15:0] ty     = stg_y[3];
  wire logic [15:0]        tmag   = ty[15] ? 16'(-ty) : ty;
  wire logic [15:0]        tmax   = tmag > run_max_reg ? tmag : run_max_reg;
  wire logic               win_end = tx_tick_reg && win_cnt_reg >= wln_reg; // [R16]
  wire logic [31:0]        tsq    = 32'(ty * ty);
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      win_cnt_reg <= 16'h0;
      run_max_reg <= 16'h0;
      tx_pk_reg   <= 16'h0;
      pwr_reg     <= 17'h0;
    end
    else if (tx_tick_reg)
    begin
      win_cnt_reg <= win_end ? 16'h0 : win_cnt_reg + 16'h1;
      run_max_reg <= win_end ? 16'h0 : tmax;
      if (win_end)
        tx_pk_reg <= tmax; // [R16]
      pwr_reg <= lndf_pkg::lndf_lp(pwr_reg, {1'b0, tsq[30:15]}, pwk_reg); // [R17]
    end
  end
  chk_txpk_window: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R16]
    !win_end |=> $stable(tx_pk_reg))
    else $error("transmit peak changed inside window");
  chk_mon_rate: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R1]
    mon_tick_reg |=> !mon_tick_reg ##1 !mon_tick_reg)
    else $error("monitor sample ticks too close");
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Purpose: Self-checking bench for lndf_top over AXI4-Lite
// Assumes: Short dividers (20 and 5) stand in for the 800 Hz and 8 kHz ticks
// Notes:   Channel 0 is exercised; channel 1 stays off and only its control and peak are read back and checked as zero
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MD = 20;
  localparam int TD = 5;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, got, exp_pk;
  logic [1:0]  rsp, off = 2'h0, trip = 2'h0, voice = 2'h0;
  logic [15:0] tv = 16'h0, rv = 16'h0, ti = 16'h0, ri = 16'h0, ev = 16'h0, ei = 16'h0;
  logic [15:0] tx = 16'h0;
  logic        awready, wready, bvalid, arready, rvalid, unbal;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          fails = 0;
  int          n_checks = 0;

  lndf_top #(.MON_DIV(MD), .TX_DIV(TD)) lndf_top_i (
    .I_CLOCK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .I_TIP_V(tv), .I_RING_V(rv), .I_TIP_I(ti), .I_RING_I(ri),
    .I_EXT_V(ev), .I_EXT_I(ei), .I_OFF_HOOK(off), .I_RING_TRIP(trip),
    .I_VOICE_ACTIVE(voice), .I_TX_SAMPLE(tx), .O_RING_UNBAL(unbal));

  always #20 clk = ~clk;

  // ======================================================================
  // Reporting
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      fails++;
    end
  endtask

  // ======================================================================
  // Bus cycles: payload held until each ready is sampled high
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50)
    begin
      fails++;
      conclude();
    end
    chk(32'(bresp), 32'(e));
    // One edge between transfers, and registered side effects have settled
    @(posedge clk);
  endtask

  task automatic rdw(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    got = rdata;
    rsp = rresp;
    if (n == 50)
    begin
      fails++;
      conclude();
    end
    @(posedge clk);
  endtask

  // ======================================================================
  // Expected values of channel 0
  function automatic logic signed [8:0] sx(input logic [15:0] x);
    return {x[7], x[7:0]};
  endfunction

  function automatic logic signed [8:0] val(input logic [2:0] s);
    logic signed [8:0] v;
    case (s)
      3'h0: v = sx(tv);
      3'h1: v = sx(rv);
      3'h2: v = sx(tv) - sx(rv);
      3'h3: v = sx(tv) + sx(rv);
      3'h4: v = sx(ti) - sx(ri);
      3'h5: v = sx(ti) + sx(ri);
      3'h6: v = sx(ev);
      default: v = sx(ei);
    endcase
    if (s == 3'h3 || s == 3'h5) v = v >>> 1;
    return v;
  endfunction

  function automatic logic [8:0] mag(input logic [2:0] s);
    logic signed [8:0] v;
    v = val(s);
    return v[8] ? 9'(-v) : 9'(v);
  endfunction

  // Fast coefficient settles one count short for positive inputs
  function automatic logic [31:0] lp1(input logic signed [16:0] d);
    return (d > 0) ? 32'(d - 17'sd1) : 32'(d);
  endfunction

  // ======================================================================
  // Main sequence
  initial
  begin
    void'($urandom(44));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdw(8'h04); chk(got, 32'h200);
    rdw(8'h44); chk(got, 32'h320);
    rdw(8'h88); chk(got, 32'h400000);
    rdw(8'h60); chk({got[29:0], rsp}, 32'h3);
    wr(8'h64, 32'h1, 2'h3);
    wr(8'h40, 32'h1, 2'h0); chk(32'(unbal), 32'h1);
    wr(8'h40, 32'h0, 2'h0); chk(32'(unbal), 32'h0);
    {tv, rv, ti, ri, ev, ei} <= {$urandom, $urandom, $urandom};
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h00, 32'(s * 2 + 1), 2'h0);
      repeat (3 * MD) @(posedge clk);
      rdw(8'h0c); chk(got, 32'(mag(3'(s))));
    end
    rdw(8'h18); chk(got, 32'(val(3'h2)));
    rdw(8'h1c); chk(got, 32'(val(3'h3)));
    rdw(8'h20); chk(got, 32'h0);
    rdw(8'h2c); chk(got, 32'h0);
    voice <= 2'h1;
    wr(8'h0c, 32'h0, 2'h0);
    repeat (3 * MD) @(posedge clk);
    rdw(8'h0c); chk(got, 32'h0);
    voice <= 2'h0;
    repeat (3 * MD) @(posedge clk);
    rdw(8'h0c); chk(got, 32'(mag(3'h7)));
    wr(8'h04, 32'hffff, 2'h0);
    wr(8'h08, 32'hffff, 2'h0);
    wr(8'h00, 32'hd, 2'h0);
    wr(8'h00, 32'hf, 2'h0);
    repeat (3 * MD) @(posedge clk);
    rdw(8'h10); chk(got, lp1(17'(val(3'h7)) * 17'sd256));
    rdw(8'h14); chk(got, lp1(17'(mag(3'h7)) * 17'sd256));
    for (int t = 0; t < 2; t++)
    begin
      wr(8'h00, 32'h1, 2'h0);
      {off, trip} <= (t == 0) ? 4'h4 : 4'h1;
      repeat (2) @(posedge clk);
      {off, trip} <= 4'h0;
      rdw(8'h00); chk(32'(got[0]), 32'h0);
    end
    tx <= 16'($signed(16'($urandom)) >>> 2);
    wr(8'h44, 32'h3, 2'h0);
    repeat (40 * TD) @(posedge clk);
    rdw(8'h48); chk(got, 32'(tx[15] ? 16'(-tx) : tx));
    wr(8'h4c, 32'hffff, 2'h0);
    wr(8'h88, 32'h800000, 2'h0);
    rdw(8'h88); chk(got, 32'h800000);
    repeat (40 * TD) @(posedge clk);
    exp_pk = 32'(tx[15] ? 16'(-tx) : tx) * 2;
    rdw(8'h48); chk(got, exp_pk);
    // Power input only rises here, so the fast average settles one count short
    rdw(8'h50); chk(got, lp1(17'((exp_pk * exp_pk) >> 15)));
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
